//--- pkg/usbr_regs.vh
// Register map, field positions, reset values and timing counts of the serial bridge
`ifndef USBR_REGS_VH
`define USBR_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define USBR_ADDR_W 4
`define USBR_OFS_CTRL 4'h0
`define USBR_OFS_BAUD 4'h4
`define USBR_OFS_STATUS 4'h8
`define USBR_OFS_TXDATA 4'hc

// ----------------------------------------
// Control fields
// ----------------------------------------
`define USBR_CTRL_DTR 0
`define USBR_CTRL_PAR_LO 1
`define USBR_CTRL_PAR_HI 2
`define USBR_CTRL_STOP2 3
`define USBR_CTRL_IFEN 4
`define USBR_CTRL_BOOT 5
`define USBR_CTRL_PROG 6
`define USBR_CTRL_DND_OK 7
`define USBR_CTRL_DND_FAIL 8
`define USBR_CTRL_PFAULT 9
`define USBR_CTRL_SLEEP 10
`define USBR_CTRL_W 11
`define USBR_CTRL_RST 11'h000

// ----------------------------------------
// Parity encodings
// ----------------------------------------
`define USBR_PAR_NONE 2'h0
`define USBR_PAR_ODD 2'h1
`define USBR_PAR_EVEN 2'h2

// ----------------------------------------
// Status fields
// ----------------------------------------
`define USBR_ST_RXVALID 0
`define USBR_ST_TXBUSY 1
`define USBR_ST_PERR 2
`define USBR_ST_FERR 3
`define USBR_ST_OVR 4
`define USBR_ST_RXDATA_LO 8

// ----------------------------------------
// Baud limits and timing
// ----------------------------------------
`define USBR_CLK_HZ 200000000
`define USBR_BAUD_MIN_BPS 1200
`define USBR_BAUD_MAX_BPS 500000
`define USBR_BAUD_RST 32'd9600
`define USBR_SLOW_HZ 1
`define USBR_FAST_HZ 5
`define USBR_DND_SEC 2
`define USBR_SLOW_HALF (`USBR_CLK_HZ / (2 * `USBR_SLOW_HZ))
`define USBR_FAST_HALF (`USBR_CLK_HZ / (2 * `USBR_FAST_HZ))
`define USBR_DND_CYC (`USBR_CLK_HZ * `USBR_DND_SEC)

`endif

//--- design/usbr_bridge.v
// Serial bridge: register slave, clamped baud generator, UART transmitter/receiver, status LED
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "usbr_regs.vh"

module usbr_bridge (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Avalon-MM slave
    input wire [`USBR_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // UART pins
    output wire uart_tx_o,
    output wire uart_tx_oe_n,
    input wire uart_rx_i,
    // Level shifter and LED
    output reg shifter_en,
    output reg power_status_led
);

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    reg [`USBR_CTRL_W-1:0] ctrl_ff;
    reg [31:0] baud_ff;
    reg [31:0] div_ff;
    reg ack_ff;
    reg [7:0] rx_data_ff;
    reg rx_valid_ff;
    reg perr_ff;
    reg ferr_ff;
    reg ovr_ff;
    reg [7:0] tx_hold_ff;
    reg tx_pend_ff;
    reg tx_busy_ff;
    reg dtr_q_ff;
    wire dtr = ctrl_ff[`USBR_CTRL_DTR];
    wire [1:0] par_mode = ctrl_ff[`USBR_CTRL_PAR_HI:`USBR_CTRL_PAR_LO];
    wire acc = (avs_read | avs_write) & ~ack_ff;
    wire wr_ctrl = acc & avs_write & (avs_address == `USBR_OFS_CTRL);
    wire wr_baud = acc & avs_write & (avs_address == `USBR_OFS_BAUD);
    wire wr_tx = acc & avs_write & (avs_address == `USBR_OFS_TXDATA);
    wire rd_stat = acc & avs_read & (avs_address == `USBR_OFS_STATUS);
    wire rx_done;
    wire [7:0] rx_byte;
    wire rx_perr;
    wire rx_ferr;
    wire tx_take;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;

    // ----------------------------------------
    // Clamped baud and divider
    // ----------------------------------------
    wire [31:0] baud_clamp = (avs_writedata < `USBR_BAUD_MIN_BPS) ? `USBR_BAUD_MIN_BPS :
        (avs_writedata > `USBR_BAUD_MAX_BPS) ? `USBR_BAUD_MAX_BPS : avs_writedata;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_ff <= `USBR_CTRL_RST;
            baud_ff <= `USBR_BAUD_RST;
            div_ff <= `USBR_CLK_HZ / `USBR_BAUD_RST;
            ack_ff <= 1'b0;
            avs_readdata <= 32'h0;
            tx_hold_ff <= 8'h00;
            tx_pend_ff <= 1'b0;
            dtr_q_ff <= 1'b0;
            shifter_en <= 1'b0;
        end else begin
            ack_ff <= acc;
            dtr_q_ff <= dtr;
            if (wr_ctrl) begin
                ctrl_ff <= avs_writedata[`USBR_CTRL_W-1:0];
            end
            if (wr_baud) begin
                baud_ff <= baud_clamp;
                div_ff <= `USBR_CLK_HZ / baud_clamp;
            end
            if (dtr) begin
                shifter_en <= 1'b1;
            end
            if (tx_take) begin
                tx_pend_ff <= 1'b0;
            end
            if (wr_tx && dtr && !tx_pend_ff) begin
                tx_hold_ff <= avs_writedata[7:0];
                tx_pend_ff <= 1'b1;
            end
            if (acc && avs_read) begin
                case (avs_address)
                    `USBR_OFS_CTRL: avs_readdata <= {{(32-`USBR_CTRL_W){1'b0}}, ctrl_ff};
                    `USBR_OFS_BAUD: avs_readdata <= baud_ff;
                    `USBR_OFS_STATUS: avs_readdata <= {16'h0, rx_data_ff, 3'h0, ovr_ff, ferr_ff, perr_ff,
                        tx_busy_ff | tx_pend_ff, rx_valid_ff};
                    default: avs_readdata <= 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Receive status (set wins over read clear)
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!reset_n) begin
            rx_data_ff <= 8'h00;
            rx_valid_ff <= 1'b0;
            perr_ff <= 1'b0;
            ferr_ff <= 1'b0;
            ovr_ff <= 1'b0;
        end else if (rx_done && dtr) begin
            rx_data_ff <= rx_byte;
            rx_valid_ff <= 1'b1;
            perr_ff <= rx_perr;
            ferr_ff <= rx_ferr;
            ovr_ff <= rx_valid_ff & ~rd_stat;
        end else if (rd_stat) begin
            rx_valid_ff <= 1'b0;
            perr_ff <= 1'b0;
            ferr_ff <= 1'b0;
            ovr_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    localparam TX_IDLE = 3'b001;
    localparam TX_SHIFT = 3'b010;
    localparam TX_STOP = 3'b100;
    reg [2:0] tx_st_ff;
    reg [31:0] tx_cnt_ff;
    reg [3:0] tx_bit_ff;
    reg [9:0] tx_sh_ff;
    reg tx_line_ff;
    reg tx_drive_ff;
    wire tx_par = ^tx_hold_ff ^ (par_mode == `USBR_PAR_ODD);
    wire [3:0] tx_nbits = (par_mode == `USBR_PAR_NONE) ? 4'd9 : 4'd10;
    assign tx_take = (tx_st_ff == TX_IDLE) & tx_pend_ff;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            tx_st_ff <= TX_IDLE;
            tx_cnt_ff <= 32'h0;
            tx_bit_ff <= 4'h0;
            tx_sh_ff <= 10'h3ff;
            tx_line_ff <= 1'b1;
            tx_busy_ff <= 1'b0;
            tx_drive_ff <= 1'b0;
        end else begin
            if (ctrl_ff[`USBR_CTRL_IFEN]) begin
                tx_drive_ff <= 1'b1;
            end
            case (tx_st_ff)
                TX_IDLE: begin
                    tx_line_ff <= 1'b1;
                    if (tx_pend_ff) begin
                        tx_sh_ff <= {tx_par, tx_hold_ff, 1'b0};
                        tx_cnt_ff <= div_ff;
                        tx_bit_ff <= 4'h0;
                        tx_busy_ff <= 1'b1;
                        tx_st_ff <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    tx_line_ff <= tx_sh_ff[0];
                    if (tx_cnt_ff <= 32'h1) begin
                        tx_cnt_ff <= div_ff;
                        tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
                        tx_bit_ff <= tx_bit_ff + 4'h1;
                        if (tx_bit_ff == tx_nbits - 4'h1) begin
                            tx_bit_ff <= 4'h0;
                            tx_st_ff <= TX_STOP;
                        end
                    end else begin
                        tx_cnt_ff <= tx_cnt_ff - 32'h1;
                    end
                end
                TX_STOP: begin
                    tx_line_ff <= 1'b1;
                    if (tx_cnt_ff <= 32'h1) begin
                        tx_cnt_ff <= div_ff;
                        tx_bit_ff <= tx_bit_ff + 4'h1;
                        if (tx_bit_ff == {3'h0, ctrl_ff[`USBR_CTRL_STOP2]}) begin
                            tx_busy_ff <= 1'b0;
                            tx_st_ff <= TX_IDLE;
                        end
                    end else begin
                        tx_cnt_ff <= tx_cnt_ff - 32'h1;
                    end
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Transmit pin
    // ----------------------------------------
    // No RTS/CTS exist on this block
    assign uart_tx_o = tx_line_ff;
    assign uart_tx_oe_n = ~tx_drive_ff;

    // ----------------------------------------
    // Receive pin synchroniser
    // ----------------------------------------
    reg [2:0] rx_sync_ff;
    reg rx_in_ff;
    always @(posedge core_clk) begin
        if (!reset_n) begin
            rx_sync_ff <= 3'b111;
            rx_in_ff <= 1'b1;
        end else begin
            rx_sync_ff <= {rx_sync_ff[1:0], uart_rx_i};
            if (rx_sync_ff[1] == rx_sync_ff[2]) begin
                rx_in_ff <= rx_sync_ff[2];
            end
        end
    end

    // ----------------------------------------
    // Receive frame
    // ----------------------------------------
    localparam RX_IDLE = 3'b001;
    localparam RX_DATA = 3'b010;
    localparam RX_STOP = 3'b100;
    reg [2:0] rx_st_ff;
    reg [31:0] rx_cnt_ff;
    reg [3:0] rx_bit_ff;
    reg [8:0] rx_sh_ff;
    reg rx_done_ff;
    reg rx_perr_ff;
    reg rx_ferr_ff;
    wire [3:0] rx_nbits = (par_mode == `USBR_PAR_NONE) ? 4'd9 : 4'd10;
    assign rx_done = rx_done_ff;
    assign rx_byte = (par_mode == `USBR_PAR_NONE) ? rx_sh_ff[8:1] : rx_sh_ff[7:0];
    assign rx_perr = rx_perr_ff;
    assign rx_ferr = rx_ferr_ff;

    always @(posedge core_clk) begin
        if (!reset_n) begin
            rx_st_ff <= RX_IDLE;
            rx_cnt_ff <= 32'h0;
            rx_bit_ff <= 4'h0;
            rx_sh_ff <= 9'h0;
            rx_done_ff <= 1'b0;
            rx_perr_ff <= 1'b0;
            rx_ferr_ff <= 1'b0;
        end else begin
            rx_done_ff <= 1'b0;
            case (rx_st_ff)
                RX_IDLE: begin
                    if (!rx_in_ff) begin
                        rx_cnt_ff <= {1'b0, div_ff[31:1]}; // Mid-bit of start
                        rx_bit_ff <= 4'h0;
                        rx_st_ff <= RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_ff <= 32'h1) begin
                        rx_cnt_ff <= div_ff;
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                        if (rx_bit_ff == 4'h0) begin
                            if (rx_in_ff) begin
                                rx_st_ff <= RX_IDLE; // False start
                            end
                        end else begin
                            rx_sh_ff <= {rx_in_ff, rx_sh_ff[8:1]};
                        end
                        if (rx_bit_ff == rx_nbits - 4'h1) begin
                            rx_st_ff <= RX_STOP;
                        end
                    end else begin
                        rx_cnt_ff <= rx_cnt_ff - 32'h1;
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_ff <= 32'h1) begin
                        // Only the first stop bit is checked; a second one reads as idle
                        rx_done_ff <= 1'b1;
                        rx_ferr_ff <= ~rx_in_ff;
                        rx_perr_ff <= (par_mode != `USBR_PAR_NONE) &
                            (^rx_sh_ff ^ (par_mode == `USBR_PAR_ODD));
                        rx_st_ff <= RX_IDLE;
                    end else begin
                        rx_cnt_ff <= rx_cnt_ff - 32'h1;
                    end
                end
                default: rx_st_ff <= RX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Power/status LED
    // ----------------------------------------
    reg [31:0] slow_cnt_ff;
    reg [31:0] fast_cnt_ff;
    reg slow_ff;
    reg fast_ff;
    reg [31:0] dnd_cnt_ff;
    reg dnd_fail_ff;
    reg [1:0] dnd_q_ff;
    wire dnd_ok_rise = ctrl_ff[`USBR_CTRL_DND_OK] & ~dnd_q_ff[0];
    wire dnd_fail_rise = ctrl_ff[`USBR_CTRL_DND_FAIL] & ~dnd_q_ff[1];

    always @(posedge core_clk) begin
        if (!reset_n) begin
            slow_cnt_ff <= 32'h0;
            fast_cnt_ff <= 32'h0;
            slow_ff <= 1'b0;
            fast_ff <= 1'b0;
            dnd_cnt_ff <= 32'h0;
            dnd_fail_ff <= 1'b0;
            dnd_q_ff <= 2'b00;
            power_status_led <= 1'b0;
        end else begin
            dnd_q_ff <= {ctrl_ff[`USBR_CTRL_DND_FAIL], ctrl_ff[`USBR_CTRL_DND_OK]};
            slow_cnt_ff <= slow_cnt_ff + 32'h1;
            if (slow_cnt_ff >= `USBR_SLOW_HALF - 1) begin
                slow_cnt_ff <= 32'h0;
                slow_ff <= ~slow_ff;
            end
            fast_cnt_ff <= fast_cnt_ff + 32'h1;
            if (fast_cnt_ff >= `USBR_FAST_HALF - 1) begin
                fast_cnt_ff <= 32'h0;
                fast_ff <= ~fast_ff;
            end
            if (dnd_ok_rise || dnd_fail_rise) begin
                dnd_cnt_ff <= `USBR_DND_CYC;
                dnd_fail_ff <= dnd_fail_rise;
            end else if (dnd_cnt_ff != 32'h0) begin
                dnd_cnt_ff <= dnd_cnt_ff - 32'h1;
            end
            if (ctrl_ff[`USBR_CTRL_SLEEP]) begin
                power_status_led <= 1'b0;
            end else if (ctrl_ff[`USBR_CTRL_PFAULT]) begin
                power_status_led <= fast_ff;
            end else if (dnd_cnt_ff != 32'h0) begin
                power_status_led <= dnd_fail_ff ? fast_ff : slow_ff;
            end else if (ctrl_ff[`USBR_CTRL_PROG] || ctrl_ff[`USBR_CTRL_BOOT]) begin
                power_status_led <= slow_ff;
            end else begin
                power_status_led <= 1'b1;
            end
        end
    end

endmodule

//--- tb/usbr_uart_peer.sv
// Target UART model on the far side of the bridge
`timescale 1ns/100ps
module usbr_uart_peer (
    // Clock
    input wire core_clk,
    // Line from the bridge
    input wire uart_tx_o,
    input wire uart_tx_oe_n,
    // Line to the bridge
    output reg uart_rx_i
);
    int div = 400;
    logic [1:0] par = 2'h0;
    logic stop2 = 1'b0;
    logic [7:0] got[$];
    int bad = 0;
    wire line = uart_tx_oe_n ? 1'b1 : uart_tx_o; // Input pull-up
    function automatic logic pbit(logic [7:0] d);
        return (par == 2'h1) ? ~^d : ^d;
    endfunction
    task automatic hold(logic v);
        uart_rx_i <= v;
        repeat (div) @(posedge core_clk);
    endtask
    // Start low, LSB first, parity, stop high
    task automatic send(logic [7:0] d, logic flip);
        hold(1'b0);
        for (int i = 0; i < 8; i++) hold(d[i]);
        if (par != 2'h0) hold(pbit(d) ^ flip);
        hold(1'b1);
        if (stop2) hold(1'b1);
    endtask
    initial begin
        uart_rx_i = 1'b1;
        forever begin
            logic [7:0] d;
            @(negedge line);
            repeat (div / 2) @(posedge core_clk);
            if (line !== 1'b0) bad++;
            for (int i = 0; i < 8; i++) begin
                repeat (div) @(posedge core_clk);
                d[i] = line;
            end
            if (par != 2'h0) begin
                repeat (div) @(posedge core_clk);
                if (line !== pbit(d)) bad++;
            end
            repeat (div) @(posedge core_clk);
            if (line !== 1'b1) bad++;
            if (stop2) begin
                repeat (div) @(posedge core_clk);
                if (line !== 1'b1) bad++;
            end
            got.push_back(d);
        end
    end
endmodule

//--- tb/usbr_bridge_sva.sv
// Port assertions of the serial bridge
`timescale 1ns/100ps
`include "usbr_regs.vh"
module usbr_bridge_sva (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Register bus
    input wire [`USBR_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // Pins
    input wire uart_tx_o,
    input wire uart_tx_oe_n,
    input wire uart_rx_i,
    input wire shifter_en,
    input wire power_status_led
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire req = avs_read | avs_write;
    wire rd_done = avs_read & !avs_waitrequest;
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no wait cycle");
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved");
    a_unmapped_zero: assert property (rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_baud_clamp: assert property (rd_done && avs_address == `USBR_OFS_BAUD |->
        avs_readdata >= `USBR_BAUD_MIN_BPS && avs_readdata <= `USBR_BAUD_MAX_BPS)
        else $error("baud out of range");
    a_oe_sticky: assert property (!uart_tx_oe_n |=> !uart_tx_oe_n)
        else $error("tx pin released");
    a_bit_min: assert property ($fell(uart_tx_o) && !uart_tx_oe_n |-> !uart_tx_o [*8])
        else $error("low bit too short");
    a_shift_hold: assert property (shifter_en |=> shifter_en)
        else $error("shifter disabled");
    a_led_on: assert property ($rose(reset_n) |-> ##[1:2] power_status_led)
        else $error("led not on");
endmodule

bind usbr_bridge usbr_bridge_sva u_sva (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .uart_tx_o(uart_tx_o), .uart_tx_oe_n(uart_tx_oe_n),
    .uart_rx_i(uart_rx_i), .shifter_en(shifter_en), .power_status_led(power_status_led));

//--- tb/usbr_bridge_tb.sv
// Self-checking bench of the serial bridge
`timescale 1ns/100ps
`include "usbr_regs.vh"
module usbr_bridge_tb;
    logic core_clk;
    logic reset_n;
    logic [`USBR_ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire uart_tx_o;
    wire uart_tx_oe_n;
    wire uart_rx_i;
    wire shifter_en;
    wire power_status_led;
    int num_errors = 0;
    int num_checks = 0;
    logic [7:0] rnd = 8'h09;
    logic [31:0] rd;
    usbr_bridge dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .uart_tx_o(uart_tx_o), .uart_tx_oe_n(uart_tx_oe_n),
        .uart_rx_i(uart_rx_i), .shifter_en(shifter_en), .power_status_led(power_status_led));
    usbr_uart_peer peer (.core_clk(core_clk), .uart_tx_o(uart_tx_o), .uart_tx_oe_n(uart_tx_oe_n),
        .uart_rx_i(uart_rx_i));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] clamp(logic [31:0] b);
        if (b < `USBR_BAUD_MIN_BPS) return `USBR_BAUD_MIN_BPS;
        if (b > `USBR_BAUD_MAX_BPS) return `USBR_BAUD_MAX_BPS;
        return b;
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic set_baud(logic [31:0] b);
        bus(1'b1, `USBR_OFS_BAUD, b);
        peer.div = `USBR_CLK_HZ / clamp(b);
        bus(1'b0, `USBR_OFS_BAUD, 32'h0);
        check(rd, clamp(b));
    endtask
    task automatic wait_tx();
        repeat (8000) if (peer.got.size() == 0) @(posedge core_clk);
    endtask
    task automatic rx_poll();
        for (int i = 0; i < 3000; i++) begin
            bus(1'b0, `USBR_OFS_STATUS, 32'h0);
            if (rd[0] === 1'b1) break;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        int k;
        reset_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        bus(1'b0, `USBR_OFS_CTRL, 32'h0);
        check(rd, `USBR_CTRL_RST);
        bus(1'b0, 4'h2, 32'h0);
        check(rd, 32'h0);
        check(uart_tx_oe_n, 1'b1);
        check(power_status_led, 1'b1);
        for (k = 0; k < 8; k++) begin
            set_baud(k < 4 ? (k * 32'd250000) + 32'd100 : rnd * 32'd3000);
            rnd = lfsr(rnd);
        end
        set_baud(32'd500000);
        $display("reset and baud tests done");
        bus(1'b1, `USBR_OFS_CTRL, 32'h10);
        repeat (2) @(posedge core_clk);
        check(uart_tx_oe_n, 1'b0);
        bus(1'b1, `USBR_OFS_TXDATA, 32'h5a);
        bus(1'b0, `USBR_OFS_STATUS, 32'h0);
        check(rd[1], 1'b0);
        repeat (4500) @(posedge core_clk);
        check(peer.got.size(), 0);
        $display("closed session test done");
        for (k = 0; k < 4; k++) begin
            bus(1'b1, `USBR_OFS_CTRL, 32'h11 | ((k % 3) << 1) | ((k & 1) << 3));
            peer.par = 2'(k % 3);
            peer.stop2 = 1'(k & 1);
            set_baud(k < 2 ? 32'd500000 : 32'd400000);
            rnd = lfsr(rnd);
            bus(1'b1, `USBR_OFS_TXDATA, {24'h0, rnd});
            wait_tx();
            check(peer.got.size(), 1);
            check(peer.got.pop_front(), rnd);
            rnd = lfsr(rnd);
            peer.send(rnd, 1'b0);
            rx_poll();
            check({rd[15:8], rd[4:0]}, {rnd, 5'h01});
        end
        check(shifter_en, 1'b1);
        check(peer.bad, 0);
        bus(1'b1, `USBR_OFS_CTRL, 32'h13);
        peer.par = 2'h1;
        peer.stop2 = 1'b0;
        peer.send(8'h66, 1'b1);
        rx_poll();
        check(rd[2], 1'b1);
        $display("session tests done");
        bus(1'b1, `USBR_OFS_CTRL, 32'h11);
        peer.par = 2'h0;
        bus(1'b1, `USBR_OFS_TXDATA, 32'ha5);
        bus(1'b1, `USBR_OFS_CTRL, 32'h10);
        wait_tx();
        check(peer.got.pop_front(), 8'ha5);
        bus(1'b1, `USBR_OFS_TXDATA, 32'h3c);
        repeat (6000) @(posedge core_clk);
        check(peer.got.size(), 0);
        peer.send(8'h77, 1'b0);
        bus(1'b0, `USBR_OFS_STATUS, 32'h0);
        check(rd[0], 1'b0);
        check(shifter_en, 1'b1);
        $display("session end test done");
        bus(1'b1, `USBR_OFS_CTRL, 32'h400);
        repeat (3) @(posedge core_clk);
        check(power_status_led, 1'b0);
        bus(1'b1, `USBR_OFS_CTRL, 32'h0);
        repeat (3) @(posedge core_clk);
        check(power_status_led, 1'b1);
        // Blinks open in the off half, far longer than the run
        bus(1'b1, `USBR_OFS_CTRL, 32'h20);
        repeat (3) @(posedge core_clk);
        check(power_status_led, 1'b0);
        bus(1'b1, `USBR_OFS_CTRL, 32'h40);
        repeat (3) @(posedge core_clk);
        check(power_status_led, 1'b0);
        bus(1'b1, `USBR_OFS_CTRL, 32'h200);
        repeat (3) @(posedge core_clk);
        check(power_status_led, 1'b0);
        bus(1'b1, `USBR_OFS_CTRL, 32'h80);
        bus(1'b1, `USBR_OFS_CTRL, 32'h0);
        repeat (3) @(posedge core_clk);
        check(power_status_led, 1'b0);
        $display("led test done");
        end_of_test();
    end
endmodule
